// [design/twfu_pkg.sv]
// package for the table word fetch unit: address map, field layout, states
// assumes a 16-bit address space shared by bit table and data register table
package twfu_pkg;
    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam int          ADDR_W       = 16;
    localparam int          WORD_W       = 16;
    localparam logic [15:0] BIT_TOP_ADDR = 16'h0FFF;  // 4095
    localparam logic [15:0] REG_BASE     = 16'h1000;  // 4096
    localparam logic [15:0] BIT_MIN_ADDR = 16'h000F;  // 15
    localparam logic [3:0]  BIT_LAST_IDX = 4'hF;
    // ----------------------------------------------------------------
    // float layout in the register pair
    // ----------------------------------------------------------------
    localparam int SIGN_POS  = 15;
    localparam int EXP_HI    = 14;
    localparam int EXP_LO    = 7;
    localparam int FRAC_HI   = 6;
    localparam int FRAC_LO   = 0;
    localparam int FRAC_W    = 23;
    localparam logic [15:0] PAIR_STEP = 16'h0001;
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        TWFU_IDLE  = 5'h01,
        TWFU_BITS  = 5'h02,
        TWFU_REG   = 5'h04,
        TWFU_FLT   = 5'h08,
        TWFU_DONE  = 5'h10
    } twfu_state_t;
endpackage

// [design/twfu_fetch.sv]
// table word fetch unit: word or float fetch from bit or register table
// assumes one-cycle synchronous read ports on both tables
`timescale 1ns/1ns
module twfu_fetch
    import twfu_pkg::*;
(
    // clock, reset, enable
    input  wire logic              SYS_CLK,
    input  wire logic              RST,
    input  wire logic              CE,
    // request from the sequencer
    input  wire logic              START,
    input  wire logic              FLOAT_REQ,
    input  wire logic              JUMPED,
    input  wire logic [ADDR_W-1:0] ADDR,
    // bit status table read port
    output logic      [ADDR_W-1:0] BIT_ADDR,
    input  wire logic              BIT_DATA,
    // data register table read port
    output logic      [ADDR_W-1:0] REG_ADDR,
    input  wire logic [WORD_W-1:0] REG_DATA,
    // result toward the stack
    output logic      [WORD_W-1:0] WORD,
    output logic      [WORD_W-1:0] WORD_LOW,
    output logic                   FLT_SIGN,
    output logic      [7:0]        FLT_EXP,
    output logic      [FRAC_W-1:0] FLT_FRAC,
    output logic                   DONE,
    output logic                   ADDR_ERR,
    output logic                   BUSY
);
    // ----------------------------------------------------------------
    // state record
    // ----------------------------------------------------------------
    typedef struct packed {
        twfu_state_t         st;
        logic [3:0]          cnt;
        logic                rd_vld;   // read issued last cycle
        logic                flt;
        logic [ADDR_W-1:0]   bit_addr;
        logic [ADDR_W-1:0]   reg_addr;
        logic [WORD_W-1:0]   word;
        logic [WORD_W-1:0]   word_low;
        logic                sign;
        logic [7:0]          expo;
        logic [FRAC_W-1:0]   frac;
        logic                done;
        logic                err;
        logic                busy;
    } twfu_regs_t;

    twfu_regs_t r;
    twfu_regs_t next_r;

    // ----------------------------------------------------------------
    // answer timing, counted in enabled cycles from the take edge
    // ----------------------------------------------------------------
    // register word: address out at take, read issued on the next edge,
    //   data sampled on the edge after, done four cycles after take
    // float pair: register n first, then n-1 once the address has moved;
    //   the second read costs two more turns, issue and sample, so done comes six cycles after
    // bit word: each bit needs one edge to issue and one to sample, so
    //   sixteen bits take thirty-two cycles and done lands at thirty-four
    // bad bit address: error flag one cycle after take, no done at all
    // a start seen while busy is not looked at; the done cycle is already
    //   idle, so a start held into it is taken as the next fetch
    // the result fields hold until the next fetch writes them again

    // ----------------------------------------------------------------
    // limits of this unit
    // ----------------------------------------------------------------
    // the sequencer must hold off while busy; there is no queue, so a
    //   second start during a fetch is simply lost
    // clock enable low freezes the walk and holds both table addresses, so
    //   the tables need not stall with it; a free-running read repeats the held address
    // the bit walk never checks what kind of module owns each bit; keeping
    //   analog and special modules out of the range is the program's job
    // a float at n = 0 would read its partner from the top of the table;
    //   the sequencer is expected never to ask for it
    // float pairs always come from the register table, whatever n is

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // table reads take one cycle, so each step samples the data of the
    // address put out on the previous cycle
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        case (r.st)
            TWFU_IDLE: begin
                next_r.busy   = 1'b0;
                next_r.rd_vld = 1'b0;
                // a jumped-over line never fetches; otherwise no condition gate
                if (START && !JUMPED) begin
                    next_r.err  = 1'b0;
                    next_r.flt  = FLOAT_REQ;
                    next_r.busy = 1'b1;
                    if (FLOAT_REQ || ADDR > BIT_TOP_ADDR) begin
                        next_r.reg_addr = ADDR;
                        next_r.cnt      = 4'h0;  // float steps on cnt[0]
                        next_r.st = FLOAT_REQ ? TWFU_FLT : TWFU_REG;
                    end else if (ADDR < BIT_MIN_ADDR) begin
                        // refuse rather than wrap below bit zero
                        next_r.err  = 1'b1;
                        next_r.busy = 1'b0;
                    end else begin
                        next_r.bit_addr = ADDR;
                        next_r.cnt      = BIT_LAST_IDX;
                        next_r.word     = '0;
                        next_r.st       = TWFU_BITS;
                    end
                end
            end
            TWFU_BITS: begin
                // two turns a bit: issue the address, then take its data,
                // walking downward without regard to module boundaries
                if (r.rd_vld) begin
                    next_r.word   = {r.word[WORD_W-2:0], BIT_DATA};
                    next_r.rd_vld = 1'b0;
                    if (r.cnt == 4'h0) begin
                        next_r.st = TWFU_DONE;
                    end else begin
                        next_r.cnt      = r.cnt - 4'h1;
                        next_r.bit_addr = r.bit_addr - PAIR_STEP;
                    end
                end else begin
                    next_r.rd_vld = 1'b1;
                end
            end
            TWFU_REG: begin
                // one turn to issue the read, one to sample the word
                next_r.rd_vld = 1'b1;
                if (r.rd_vld) begin
                    next_r.word   = REG_DATA;
                    next_r.rd_vld = 1'b0;
                    next_r.st     = TWFU_DONE;
                end
            end
            TWFU_FLT: begin
                // first read register N, then the pair partner N-1
                next_r.rd_vld = 1'b1;
                if (r.rd_vld && !r.cnt[0]) begin
                    next_r.word     = REG_DATA;
                    next_r.reg_addr = r.reg_addr - PAIR_STEP;
                    next_r.cnt      = 4'h1;
                    next_r.rd_vld   = 1'b0;
                end else if (r.rd_vld) begin
                    next_r.word_low = REG_DATA;
                    next_r.sign     = r.word[SIGN_POS];
                    next_r.expo     = r.word[EXP_HI:EXP_LO];
                    next_r.frac     = {r.word[FRAC_HI:FRAC_LO],
                                       REG_DATA};
                    next_r.rd_vld   = 1'b0;
                    next_r.st       = TWFU_DONE;
                end
            end
            TWFU_DONE: begin
                // done for one cycle, then idle where a new start may land
                next_r.done = 1'b1;
                next_r.busy = 1'b0;
                next_r.cnt  = 4'h0;
                next_r.st   = TWFU_IDLE;
            end
            default: begin
                next_r.st = TWFU_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // reset leaves every output low; the enable holds the whole record,
    // so a stalled fetch resumes on exactly the step where it stopped
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            r    <= '0;
            r.st <= TWFU_IDLE;
        end else if (CE) begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs straight from the record
    // ----------------------------------------------------------------
    // table read addresses, registered so the tables see a clean edge
    assign BIT_ADDR = r.bit_addr;
    assign REG_ADDR = r.reg_addr;
    // result word and the raw float pair
    assign WORD     = r.word;
    assign WORD_LOW = r.word_low;
    // decoded float fields, only meaningful after a float fetch
    assign FLT_SIGN = r.sign;
    assign FLT_EXP  = r.expo;
    assign FLT_FRAC = r.frac;
    // status toward the sequencer
    assign DONE     = r.done;
    assign ADDR_ERR = r.err;
    assign BUSY     = r.busy;
endmodule

// [verification/twfu_fetch_properties.sv]
// checker for the table word fetch unit, bound onto twfu_fetch
// assumes CE held high, so the answer counts are in plain cycles
`timescale 1ns/1ns
module twfu_fetch_checker
    import twfu_pkg::*;
(
    // clock and control
    input wire logic              SYS_CLK,
    input wire logic              RST,
    input wire logic              CE,
    input wire logic              START,
    input wire logic              FLOAT_REQ,
    input wire logic              JUMPED,
    input wire logic [ADDR_W-1:0] ADDR,
    // results
    input wire logic [WORD_W-1:0] WORD,
    input wire logic [WORD_W-1:0] WORD_LOW,
    input wire logic              FLT_SIGN,
    input wire logic [7:0]        FLT_EXP,
    input wire logic [FRAC_W-1:0] FLT_FRAC,
    input wire logic              DONE,
    input wire logic              ADDR_ERR,
    input wire logic              BUSY
);
    // a request the unit really takes; the done cycle is already idle,
    // so a start held into it is taken like any other
    wire  acc = START & CE & ~BUSY & ~JUMPED;
    wire  bit_ok = ~FLOAT_REQ & (ADDR <= BIT_TOP_ADDR);
    logic flt_q;
    // kind of the last taken fetch, so float fields are judged only then
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) flt_q <= 1'b0;
        else if (acc) flt_q <= FLOAT_REQ;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    chk_done_pulse: assert property (DONE |=> !DONE)
        else $error("done held longer than one cycle");
    chk_float_sign: assert property (
        DONE && flt_q |-> FLT_SIGN == WORD[SIGN_POS])
        else $error("float sign not from bit 15 of high word");
    chk_float_exp: assert property (
        DONE && flt_q |-> FLT_EXP == WORD[EXP_HI:EXP_LO])
        else $error("float exponent field misplaced");
    chk_frac_split: assert property (
        DONE && flt_q |-> FLT_FRAC == {WORD[FRAC_HI:FRAC_LO], WORD_LOW})
        else $error("float fraction not split over the pair");
    chk_reg_time: assert property (
        acc && !FLOAT_REQ && ADDR >= REG_BASE |-> ##4 DONE)
        else $error("register fetch not done in four cycles");
    chk_bit_time: assert property (
        acc && bit_ok && ADDR >= BIT_MIN_ADDR |-> ##34 DONE)
        else $error("bit fetch not done in 34 cycles");
    chk_pair_time: assert property (acc && FLOAT_REQ |-> ##6 DONE)
        else $error("float pair fetch not done in six cycles");
    chk_low_error: assert property (
        acc && bit_ok && ADDR < BIT_MIN_ADDR |=> (ADDR_ERR && !BUSY)[*3])
        else $error("low bit address not flagged");
    cov_float: cover property (DONE && flt_q);
    cov_error: cover property (ADDR_ERR);
    cov_bits: cover property (acc && bit_ok);
endmodule
bind twfu_fetch twfu_fetch_checker chk_u (
    .SYS_CLK   (SYS_CLK),
    .RST       (RST),
    .CE        (CE),
    .START     (START),
    .FLOAT_REQ (FLOAT_REQ),
    .JUMPED    (JUMPED),
    .ADDR      (ADDR),
    .WORD      (WORD),
    .WORD_LOW  (WORD_LOW),
    .FLT_SIGN  (FLT_SIGN),
    .FLT_EXP   (FLT_EXP),
    .FLT_FRAC  (FLT_FRAC),
    .DONE      (DONE),
    .ADDR_ERR  (ADDR_ERR),
    .BUSY      (BUSY)
);

// [verification/twfu_tables.sv]
// bit status and data register tables behind the fetch unit
// assumes one-cycle synchronous reads; contents are an address pattern
`timescale 1ns/1ns
module twfu_tables
    import twfu_pkg::*;
(
    // clock and read ports
    input  wire logic              SYS_CLK,
    input  wire logic [ADDR_W-1:0] BIT_ADDR,
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    output logic                   BIT_DATA,
    output logic      [WORD_W-1:0] REG_DATA
);
    // discrete bits only: no analog module sits in any fetched range
    always_ff @(posedge SYS_CLK) begin
        BIT_DATA <= BIT_ADDR[0] ^ BIT_ADDR[3] ^ BIT_ADDR[8];
        REG_DATA <= {REG_ADDR[7:0], ~REG_ADDR[15:8]};
    end
endmodule

// [verification/table_word_fetch_unit_bench.sv]
// self-checking bench for the table word fetch unit
// assumes twfu_tables stands in for both tables; CE tied high
`timescale 1ns/1ns
module table_word_fetch_unit_bench;
    import twfu_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, start = 1'b0, flt = 1'b0;
    logic        jmp = 1'b0, bit_data, flt_sign, done, addr_err, busy;
    logic [15:0] addr = 16'h0000, bit_addr, reg_addr, reg_data, word, low;
    logic [7:0]  flt_exp;
    logic [22:0] flt_frac;
    int          bad_count = 0;
    int          samples_checked = 0;
    twfu_tables tab_u (.SYS_CLK(clk), .BIT_ADDR(bit_addr),
        .REG_ADDR(reg_addr), .BIT_DATA(bit_data), .REG_DATA(reg_data));
    twfu_fetch dut_u (.SYS_CLK(clk), .RST(rst), .CE(1'b1), .START(start),
        .FLOAT_REQ(flt), .JUMPED(jmp), .ADDR(addr), .BIT_ADDR(bit_addr),
        .BIT_DATA(bit_data), .REG_ADDR(reg_addr), .REG_DATA(reg_data),
        .WORD(word), .WORD_LOW(low), .FLT_SIGN(flt_sign), .FLT_EXP(flt_exp),
        .FLT_FRAC(flt_frac), .DONE(done), .ADDR_ERR(addr_err), .BUSY(busy));
    initial begin
        forever #5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request, then wait for the done pulse under a fixed bound
    task automatic fetch(input logic [15:0] a, input logic f, j, want);
        logic seen;
        seen = 1'b0;
        @(negedge clk);
        addr = a;
        flt = f;
        jmp = j;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (int n = 0; n < 50 && !seen; n++) begin
            @(negedge clk);
            seen = (done === 1'b1);
        end
        check(seen, want);
        if (want && !seen) close_out();
    endtask
    function automatic logic [15:0] regv(input logic [15:0] x);
        return {x[7:0], ~x[15:8]};
    endfunction
    // addressed bit is the msb, the fifteen lower addresses follow down
    function automatic logic [15:0] bits(input logic [15:0] x);
        logic [15:0] w;
        for (int i = 0; i < 16; i++) w[15-i] = ^(16'(x - i) & 16'h0109);
        return w;
    endfunction
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reg();
        fetch(16'h1000, 1'b0, 1'b0, 1'b1);
        check(word, regv(16'h1000));
        fetch(16'hFFFF, 1'b0, 1'b0, 1'b1);
        check(word, regv(16'hFFFF));
        $display("register fetch test ended");
    endtask
    task automatic t_bits();
        logic [15:0] a [3] = '{16'h0FFF, 16'h000F, 16'h0107};
        foreach (a[k]) begin
            fetch(a[k], 1'b0, 1'b0, 1'b1);
            check(word, bits(a[k]));
        end
        $display("bit fetch test ended");
    endtask
    // second address gives a set sign bit in the high register
    task automatic t_flt();
        logic [15:0] n [2] = '{16'h1234, 16'h1280};
        logic [15:0] hi;
        logic [15:0] lo;
        foreach (n[k]) begin
            hi = regv(n[k]);
            lo = regv(n[k] - 16'h0001);
            fetch(n[k], 1'b1, 1'b0, 1'b1);
            check(word, hi);
            check(low, lo);
            check(flt_sign, hi[15]);
            check(flt_exp, hi[14:7]);
            check({flt_sign, flt_exp, flt_frac}, {hi, lo});
        end
        $display("float fetch test ended");
    endtask
    task automatic t_odd();
        fetch(16'h000E, 1'b0, 1'b0, 1'b0);
        check(addr_err, 1'b1);
        fetch(16'h1000, 1'b0, 1'b1, 1'b0);
        check(busy, 1'b0);
        check(addr_err, 1'b1);
        // an accepted fetch clears the error flag again
        fetch(16'h1001, 1'b0, 1'b0, 1'b1);
        check(addr_err, 1'b0);
        check(word, regv(16'h1001));
        $display("error and jump test ended");
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_reg();
        t_bits();
        t_flt();
        t_odd();
        close_out();
    end
endmodule
